/* verif/acq_interrupt_unit_test.sv */
// self-checking testbench of the acquisition interrupt unit
`timescale 1ns/1ns
`default_nettype none
module acq_interrupt_unit_test;
    localparam int SETTLE = 20;
    logic                  clock = 1'b0;
    logic                  nrst = 1'b0;
    logic                  cs_n, rd_n, wr_n, bus_width_sel, data_oe_n, irq_n;
    logic [4:0]            addr;
    logic [15:0]           data_in, data_out;
    logic                  low_supply = 1'b0;
    aiu_pkg::aiu_seq_type  seq = '0;
    aiu_pkg::aiu_wd_type   wd = '0;
    logic [5:0]            fifo_count = 6'h00;
    logic                  short_az_done = 1'b0;
    logic                  full_cal_done = 1'b0;
    logic                  standby = 1'b0;
    logic                  dev_reset = 1'b0;
    int                    err_total = 0;
    int                    check_count = 0;

    // clock and units
    always #5 clock = ~clock;
    aiu_top #(.SETTLE_CYCLES(SETTLE)) DUT (.clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .bus_width_sel(bus_width_sel), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .irq_n(irq_n), .low_supply(low_supply),
        .seq(seq), .wd(wd), .fifo_count(fifo_count), .short_az_done(short_az_done),
        .full_cal_done(full_cal_done), .standby(standby), .dev_reset(dev_reset));
    aiu_host host (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .bus_width_sel(bus_width_sel), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

    // comparison and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic irq_is(input logic v);
        check({15'h0000, irq_n}, {15'h0000, v});
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic        oe;
        host.xfer(1'b0, a, 16'h0000, q, oe);
        check({15'h0000, oe}, 16'h0000);
        check(q, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        oe;
        host.xfer(1'b1, a, d, q, oe);
    endtask
    task automatic set_enable(input logic [15:0] d);
        logic [15:0] q;
        logic        oe;
        wr({aiu_pkg::IDX_ENABLE, 1'b0}, d);
        host.xfer(1'b0, {aiu_pkg::IDX_STATUS, 1'b0}, 16'h0000, q, oe);
    endtask
    task automatic rd_st(input logic [15:0] exp);
        rd_chk({aiu_pkg::IDX_STATUS, 1'b0}, exp);
    endtask
    task automatic pulse_wd(input aiu_pkg::aiu_wd_type w);
        wd = w;
        cyc(1);
        wd.done = 1'b0;
    endtask
    task automatic fetch(input logic [2:0] p, input logic pz);
        seq.ptr = p;
        seq.pause = pz;
        seq.fetch = 1'b1;
        cyc(1);
        seq.fetch = 1'b0;
        seq.pause = 1'b0;
    endtask

    // raise one source's event
    task automatic fire(input int i);
        case (i)
            0: pulse_wd('{1'b1, 13'sd100, 13'sd50, 1'b1, 13'sd200, 1'b1});
            1: fetch(3'h2, 1'b0);
            2: begin
                fifo_count = 6'h02;
                cyc(1);
                fifo_count = 6'h03;
                cyc(1);
                fifo_count = 6'h00;
            end
            3: begin short_az_done = 1'b1; cyc(1); short_az_done = 1'b0; end
            4: begin full_cal_done = 1'b1; cyc(1); full_cal_done = 1'b0; end
            5: fetch(3'h0, 1'b1);
            6: begin low_supply = 1'b1; cyc(2); low_supply = 1'b0; cyc(4); end
            default: begin
                standby = 1'b1;
                cyc(3);
                standby = 1'b0;
                cyc(SETTLE - 1);
                irq_is(1'b1);
                cyc(5);
            end
        endcase
    endtask

    // reset state, unmapped and read-only places
    task automatic t_reset;
        irq_is(1'b1);
        check({15'h0000, data_oe_n}, 16'h0001);
        rd_chk({aiu_pkg::IDX_ENABLE, 1'b0}, aiu_pkg::ENABLE_RESET);
        rd_st(16'h0000);
        rd_chk({4'h3, 1'b0}, 16'h0000);
        wr({aiu_pkg::IDX_STATUS, 1'b0}, 16'hffff);
        rd_st(16'h0000);
    endtask
    // every source sets its flag and drives the pin, read clears it
    task automatic t_sources;
        set_enable(16'h1aff);
        rd_chk({aiu_pkg::IDX_ENABLE, 1'b0}, 16'h1aff);
        for (int i = 0; i < 8; i++) begin
            fire(i);
            cyc(3);
            irq_is(1'b0);
            rd_st(16'(1 << i));
            cyc(2);
            irq_is(1'b1);
            rd_st(16'h0000);
        end
    endtask
    // masking gates the pin only
    task automatic t_mask;
        set_enable(16'h1a10);
        fire(3);
        cyc(3);
        irq_is(1'b1);
        fire(4);
        cyc(3);
        irq_is(1'b0);
        rd_st(16'h0018);
    endtask
    // watchdog direction bits
    task automatic t_wd;
        pulse_wd('{1'b1, -13'sd10, 13'sd0, 1'b0, 13'sd20, 1'b1});
        rd_st(16'h0001);
        pulse_wd('{1'b1, 13'sd10, 13'sd0, 1'b0, 13'sd20, 1'b1});
        rd_st(16'h0000);
    endtask
    // trigger zero skips the first fetch after start
    task automatic t_trig0;
        set_enable(16'h1802);
        dev_reset = 1'b1;
        cyc(2);
        dev_reset = 1'b0;
        seq.start = 1'b1;
        cyc(1);
        seq.start = 1'b0;
        fetch(3'h0, 1'b0);
        rd_st(16'h0000);
        fetch(3'h0, 1'b0);
        rd_st(16'h0002);
    endtask
    // fifo threshold at 31 and at the undefined zero
    task automatic t_fifo;
        set_enable(16'hf800);
        fifo_count = 6'd30;
        cyc(2);
        rd_st(16'h0000);
        fifo_count = 6'd31;
        cyc(2);
        rd_st(16'h0004);
        rd_st(16'h0000);
        set_enable(16'h0000);
        fifo_count = 6'd0;
        cyc(2);
        rd_st(16'h0000);
    endtask
    // live pointer and count, device reset beats events
    task automatic t_progress;
        seq.running = 1'b1;
        seq.ptr = 3'h5;
        fifo_count = 6'd7;
        cyc(2);
        rd_st(16'h3d00);
        fire(3);
        seq.running = 1'b0;
        dev_reset = 1'b1;
        fire(4);
        cyc(1);
        dev_reset = 1'b0;
        fifo_count = 6'd0;
        rd_st(16'h0000);
    endtask
    // byte-wide bus clears only on the high-byte read
    task automatic t_byte;
        host.bus_width_sel = 1'b1;
        cyc(4);
        fire(4);
        rd_chk({aiu_pkg::IDX_STATUS, 1'b0}, 16'h0010);
        rd_chk({aiu_pkg::IDX_STATUS, 1'b0}, 16'h0010);
        rd_chk({aiu_pkg::IDX_STATUS, 1'b1}, 16'h0000);
        rd_chk({aiu_pkg::IDX_STATUS, 1'b0}, 16'h0000);
        host.bus_width_sel = 1'b0;
        cyc(4);
    endtask

    // main sequence
    initial begin
        cyc(2);
        nrst = 1'b1;
        cyc(2);
        t_reset;
        t_sources;
        t_mask;
        t_wd;
        t_trig0;
        t_fifo;
        t_progress;
        t_byte;
        wrap_up;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire

/* verif/aiu_host.sv */
// host processor bus model driving the unit's parallel register pins
`timescale 1ns/1ns
`default_nettype none
module aiu_host (
    // clock
    input  wire logic        clock,
    // strobes and address
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [4:0]       addr,
    output logic             bus_width_sel,
    // data pins
    output logic [15:0]      data_in,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe_n
);
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 5'h00;
        bus_width_sel = 1'b0;
        data_in = 16'h5a5a;
    end

    // one access: strobe low five cycles, select one more, address and data three more
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic oe_n);
        @(negedge clock);
        addr = a;
        data_in = wr ? d : ~data_in;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (5) @(negedge clock);
        q = data_out;
        oe_n = data_oe_n;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge clock);
        cs_n = 1'b1; // select outlives the strobe so its rising end is seen
        repeat (3) @(negedge clock);
        data_in = ~data_in; // released bus never shows the last value
    endtask
endmodule
`default_nettype wire

/* verilog/aiu_flag.sv */
// one sticky status flag with its mask gate
`timescale 1ns/1ns
`default_nettype none
module aiu_flag (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // control
    input  wire logic set,
    input  wire logic read_clr,
    input  wire logic dev_clr,
    input  wire logic enable,
    // state
    output logic      flag,
    output logic      pending
);
    logic flag_ff;

    // device reset first, then set beats a read clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag_ff <= 1'b0;
        end else if (dev_clr) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (read_clr) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag    = flag_ff;
    assign pending = flag_ff & enable;
endmodule
`default_nettype wire

/* verilog/aiu_pkg.sv */
// package: constants and carrier types of the acquisition interrupt unit
// Contract
// - eight equal sources drive low interrupt pin
// - flags set regardless of enable bits
// - status read or device reset clears flags
// - watchdog limit crossing per direction bit
// - pointer match sets flag before execution
// - trigger zero skips first fetch after start
// - fifo count equals threshold one to 31
// - short and full calibration completion events
// - fetch of pause instruction sets flag
// - low supply indication sets flag
// - standby exit flags after settle delay
// - enable bits gate sources onto pin
// - interrupts never halt the sequencer
// - status shows instruction pointer while running
// - status shows fifo count while running
// - device reset clears all flags
package aiu_pkg;
    // register indices on the word address lines
    localparam logic [3:0] IDX_ENABLE = 4'h9;
    localparam logic [3:0] IDX_STATUS = 4'ha;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;
    // field positions
    localparam int NUM_SRC     = 8;
    localparam int TRIG_LSB    = 8;
    localparam int TRIG_W      = 3;
    localparam int THR_LSB     = 11;
    localparam int THR_W       = 5;
    localparam int PTR_LSB     = 8;
    localparam int CNT_LSB     = 11;
    // source numbers
    localparam int SRC_WATCHDOG = 0;
    localparam int SRC_POINTER  = 1;
    localparam int SRC_FIFO     = 2;
    localparam int SRC_SHORT_AZ = 3;
    localparam int SRC_FULL_CAL = 4;
    localparam int SRC_PAUSE    = 5;
    localparam int SRC_LOW_SUP  = 6;
    localparam int SRC_STANDBY  = 7;
    // settle delay after standby exit
    localparam int CLK_KHZ        = 100000;
    localparam int SETTLE_MS      = 10;
    localparam int SETTLE_CYCLES  = SETTLE_MS * CLK_KHZ;
    localparam int WD_W           = 13;
    localparam int CNT_W          = 6;

    // sequencer fetch strobe with its instruction
    typedef struct packed {
        logic       fetch;
        logic       pause;
        logic [2:0] ptr;
        logic       running;
        logic       start;
    } aiu_seq_type;

    // one watchdog comparison pair
    typedef struct packed {
        logic                   done;
        logic signed [WD_W-1:0] sample;
        logic signed [WD_W-1:0] limit1;
        logic                   above1;
        logic signed [WD_W-1:0] limit2;
        logic                   above2;
    } aiu_wd_type;
endpackage

/* verilog/aiu_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module aiu_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // pin side and synchronised side
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage read only by second stage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

/* verilog/aiu_top.sv */
// interrupt unit: enable and status registers, sources, interrupt pin
`timescale 1ns/1ns
`default_nettype none
module aiu_top #(
    parameter int SETTLE_CYCLES = aiu_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // parallel register bus pins
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                wr_n,
    input  wire logic [4:0]          addr,
    input  wire logic                bus_width_sel,
    input  wire logic [15:0]         data_in,
    output logic      [15:0]         data_out,
    output logic                     data_oe_n,
    // interrupt pin
    output logic                     irq_n,
    // analog supply monitor pin
    input  wire logic                low_supply,
    // device-internal event sources
    input  wire aiu_pkg::aiu_seq_type seq,
    input  wire aiu_pkg::aiu_wd_type  wd,
    input  wire logic [aiu_pkg::CNT_W-1:0] fifo_count,
    input  wire logic                short_az_done,
    input  wire logic                full_cal_done,
    input  wire logic                standby,
    input  wire logic                dev_reset
);
    localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

    // refuse a settle count the start check cannot serve
    if (SETTLE_CYCLES < 2) begin : g_bad_settle
        $error("settle count must be at least two cycles");
    end

    // synchronised pin copies
    logic        cs_n_s;
    logic        rd_n_s;
    logic        wr_n_s;
    logic        bw_s;
    logic        low_sup_s;
    logic [4:0]  addr_s;
    logic [15:0] din_s;
    logic        rd_n_d_ff;
    logic        wr_n_d_ff;

    // registers and state
    logic [15:0]            enable_ff;
    logic [aiu_pkg::NUM_SRC-1:0] flags;
    logic [aiu_pkg::NUM_SRC-1:0] pend;
    logic [aiu_pkg::NUM_SRC-1:0] src_evt;
    logic                   irq_n_ff;
    logic [15:0]            data_out_ff;
    logic                   first_fetch_ff;
    logic                   thr_match_d_ff;
    logic                   standby_d_ff;
    logic                   settle_busy_ff;
    logic [SET_W-1:0]       settle_cnt_ff;
    logic [2:0]             ptr_view_ff;
    logic [4:0]             cnt_view_ff;

    // decoded bus events
    logic       rd_act;
    logic       rd_end;
    logic       wr_end;
    logic [3:0] widx;
    logic       read_clr;
    logic [2:0] trig;
    logic [4:0] thr;
    logic       thr_match;
    logic       wd_hit;
    logic       ptr_hit;
    logic       settle_done;
    logic       any_pend;
    logic [15:0] status_word;
    logic [15:0] word_sel;

    // two flip-flops on every pin input
    aiu_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_ctl (
        .clock (clock),
        .nrst  (nrst),
        .din   ({cs_n, rd_n, wr_n}),
        .dout  ({cs_n_s, rd_n_s, wr_n_s})
    );
    aiu_sync #(.WIDTH(23), .RST_VAL(23'h000000)) u_sync_dat (
        .clock (clock),
        .nrst  (nrst),
        .din   ({bus_width_sel, low_supply, addr, data_in}),
        .dout  ({bw_s, low_sup_s, addr_s, din_s})
    );

    // strobe edges from the synchronised copies
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_n_d_ff <= 1'b1;
            wr_n_d_ff <= 1'b1;
        end else begin
            rd_n_d_ff <= rd_n_s;
            wr_n_d_ff <= wr_n_s;
        end
    end

    // word index from A4-A1 in both widths
    assign widx   = addr_s[4:1];
    assign rd_act = !cs_n_s && !rd_n_s;
    assign rd_end = !cs_n_s && rd_n_s && !rd_n_d_ff;
    assign wr_end = !cs_n_s && wr_n_s && !wr_n_d_ff;
    // 8-bit bus clears on the upper byte read
    assign read_clr = rd_end && (widx == aiu_pkg::IDX_STATUS)
                      && (!bw_s || addr_s[0]);

    // enable register, byte lanes on the narrow bus
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            enable_ff <= aiu_pkg::ENABLE_RESET;
        end else if (wr_end && widx == aiu_pkg::IDX_ENABLE) begin
            if (!bw_s) begin
                enable_ff <= din_s;
            end else if (addr_s[0]) begin
                enable_ff[15:8] <= din_s[7:0];
            end else begin
                enable_ff[7:0] <= din_s[7:0];
            end
        end
    end

    assign trig = enable_ff[aiu_pkg::TRIG_LSB +: aiu_pkg::TRIG_W];
    assign thr  = enable_ff[aiu_pkg::THR_LSB +: aiu_pkg::THR_W];

    // watchdog: either comparison of the pair crossing its limit
    assign wd_hit = wd.done && ((wd.above1 ? (wd.sample > wd.limit1) : (wd.sample < wd.limit1))
                    || (wd.above2 ? (wd.sample > wd.limit2) : (wd.sample < wd.limit2)));

    // first fetch after start or device reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            first_fetch_ff <= 1'b1;
        end else if (dev_reset || seq.start) begin
            first_fetch_ff <= 1'b1;
        end else if (seq.fetch) begin
            first_fetch_ff <= 1'b0;
        end
    end

    // pointer match at fetch, ahead of execution
    assign ptr_hit = seq.fetch && (seq.ptr == trig)
                     && !(first_fetch_ff && trig == 3'h0);

    // fifo threshold reached, zero threshold ignored
    assign thr_match = (thr != 5'h00) && (fifo_count == {1'b0, thr});

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            thr_match_d_ff <= 1'b0;
        end else begin
            thr_match_d_ff <= thr_match;
        end
    end

    // settle counter after leaving standby
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            standby_d_ff   <= 1'b0;
            settle_busy_ff <= 1'b0;
            settle_cnt_ff  <= '0;
        end else begin
            standby_d_ff <= standby;
            if (standby) begin
                settle_busy_ff <= 1'b0;
            end else if (standby_d_ff) begin
                settle_busy_ff <= 1'b1;
                settle_cnt_ff  <= SET_W'(SETTLE_CYCLES - 1);
            end else if (settle_busy_ff) begin
                if (settle_cnt_ff == '0) begin
                    settle_busy_ff <= 1'b0;
                end else begin
                    settle_cnt_ff <= settle_cnt_ff - 1'b1;
                end
            end
        end
    end

    assign settle_done = settle_busy_ff && !standby && (settle_cnt_ff == '0);

    // source events into flag positions
    always_comb begin
        src_evt                        = '0;
        src_evt[aiu_pkg::SRC_WATCHDOG] = wd_hit;
        src_evt[aiu_pkg::SRC_POINTER]  = ptr_hit;
        src_evt[aiu_pkg::SRC_FIFO]     = thr_match && !thr_match_d_ff;
        src_evt[aiu_pkg::SRC_SHORT_AZ] = short_az_done;
        src_evt[aiu_pkg::SRC_FULL_CAL] = full_cal_done;
        src_evt[aiu_pkg::SRC_PAUSE]    = seq.fetch && seq.pause;
        src_evt[aiu_pkg::SRC_LOW_SUP]  = low_sup_s;
        src_evt[aiu_pkg::SRC_STANDBY]  = settle_done;
    end

    // eight identical sticky flags
    for (genvar k = 0; k < aiu_pkg::NUM_SRC; k++) begin : g_flag
        aiu_flag u_flag (
            .clock    (clock),
            .nrst     (nrst),
            .set      (src_evt[k]),
            .read_clr (read_clr),
            .dev_clr  (dev_reset),
            .enable   (enable_ff[k]),
            .flag     (flags[k]),
            .pending  (pend[k])
        );
    end

    // level interrupt, no path back to the sequencer
    assign any_pend = |pend;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= !any_pend;
        end
    end

    // live pointer and count while running, held when stopped, cleared by device reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ptr_view_ff <= 3'h0;
            cnt_view_ff <= 5'h00;
        end else if (dev_reset) begin
            ptr_view_ff <= 3'h0;
            cnt_view_ff <= 5'h00;
        end else if (seq.running) begin
            ptr_view_ff <= seq.ptr;
            cnt_view_ff <= fifo_count[4:0];
        end
    end

    assign status_word = {cnt_view_ff, ptr_view_ff, flags};

    // read mux with byte steering on the narrow bus
    always_comb begin
        case (widx)
            aiu_pkg::IDX_ENABLE: word_sel = enable_ff;
            aiu_pkg::IDX_STATUS: word_sel = status_word;
            default:             word_sel = aiu_pkg::RDATA_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_out_ff <= aiu_pkg::RDATA_IDLE;
        end else if (rd_act) begin
            if (!bw_s) begin
                data_out_ff <= word_sel;
            end else if (addr_s[0]) begin
                data_out_ff <= {8'h00, word_sel[15:8]};
            end else begin
                data_out_ff <= {8'h00, word_sel[7:0]};
            end
        end
    end

    assign data_out  = data_out_ff;
    assign data_oe_n = !rd_act;
    assign irq_n     = irq_n_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_irq_level;
        1 |=> (irq_n == !$past(any_pend));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt pin does not follow pending");

    property p_pin_low;
        any_pend |=> !irq_n;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("unmasked flag did not pull pin low");

    property p_set_unmasked;
        (src_evt != '0 && !dev_reset) |=> ((flags & $past(src_evt)) == $past(src_evt));
    endproperty
    a_set_unmasked: assert property (p_set_unmasked) else $error("event did not set its flag");

    property p_read_clear;
        (read_clr && src_evt == '0 && !dev_reset) |=> (flags == '0);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read left a flag set");

    property p_dev_clear;
        dev_reset |=> (flags == '0 && ptr_view_ff == 3'h0);
    endproperty
    a_dev_clear: assert property (p_dev_clear) else $error("device reset left state");

    property p_ptr_match;
        (seq.fetch && seq.ptr == trig && trig != 3'h0 && !dev_reset) |=> flags[aiu_pkg::SRC_POINTER];
    endproperty
    a_ptr_match: assert property (p_ptr_match) else $error("pointer match missed");

    property p_first_zero;
        (seq.fetch && first_fetch_ff && seq.ptr == 3'h0 && trig == 3'h0
         && !flags[aiu_pkg::SRC_POINTER]) |=> !flags[aiu_pkg::SRC_POINTER];
    endproperty
    a_first_zero: assert property (p_first_zero) else $error("first fetch of zero flagged");

    property p_fifo_zero;
        (thr == 5'h00 && !flags[aiu_pkg::SRC_FIFO]) |=> !flags[aiu_pkg::SRC_FIFO];
    endproperty
    a_fifo_zero: assert property (p_fifo_zero) else $error("zero threshold fired");

    property p_settle_start;
        (!standby && standby_d_ff) |=> (settle_busy_ff && !src_evt[aiu_pkg::SRC_STANDBY]);
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("settle delay not started");

    property p_ptr_view;
        (seq.running && !dev_reset) |=> (status_word[10:8] == $past(seq.ptr));
    endproperty
    a_ptr_view: assert property (p_ptr_view) else $error("pointer view stale");
endmodule
`default_nettype wire
